// [verilog/stls_pkg.sv]
package stls_pkg;
   // limits are whole percent of rated torque
   localparam int               LIM_W          = 10;
   localparam logic [LIM_W-1:0] LIM_RANGE_MAX  = 10'h12c;
   localparam logic [LIM_W-1:0] LIM_DEFAULT    = 10'h12c;
   localparam int               AIN_W          = 16;
   localparam int               TC_W           = 4;
   localparam int               FILT_FRAC      = 8;
   localparam int               SCALE_SHIFT    = 10;
   localparam logic [15:0]      SCALE_DEFAULT  = 16'h001e;
   localparam logic [2:0]       SEL_DEFAULT    = 3'h1;
   localparam int               NUM_PINS       = 10;
   localparam int               PIN_IDX_W      = 4;

   // apb register byte offsets
   localparam int               ADDR_W         = 8;
   localparam logic [ADDR_W-1:0] OFS_SELECT     = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_FIRST      = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_SECOND     = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_RATE12     = 8'h0c;
   localparam logic [ADDR_W-1:0] OFS_RATE21     = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_FWD_EXT    = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_REV_EXT    = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_SCALE      = 8'h1c;
   localparam logic [ADDR_W-1:0] OFS_AIN2_OFS   = 8'h20;
   localparam logic [ADDR_W-1:0] OFS_AIN2_TC    = 8'h24;
   localparam logic [ADDR_W-1:0] OFS_AIN3_OFS   = 8'h28;
   localparam logic [ADDR_W-1:0] OFS_AIN3_TC    = 8'h2c;
   localparam logic [ADDR_W-1:0] OFS_PAIR_MAX   = 8'h30;
   localparam logic [ADDR_W-1:0] OFS_SW_MAP     = 8'h34;
   localparam logic [ADDR_W-1:0] OFS_STATUS     = 8'h38;

   // field positions
   localparam int MAP_INV_BIT    = 4;
   localparam int MAP_EN_BIT     = 5;
   localparam int STAT_REV_LSB   = 16;
   localparam int STAT_BUSY_BIT  = 26;
   localparam int STAT_SW_BIT    = 27;
   localparam int STAT_ACT_BIT   = 28;

   // selection settings
   localparam logic [2:0] SEL_ANALOG_BIPOLAR  = 3'h0;
   localparam logic [2:0] SEL_FIRST_BOTH      = 3'h1;
   localparam logic [2:0] SEL_FIRST_SECOND    = 3'h2;
   localparam logic [2:0] SEL_SWITCHED        = 3'h3;
   localparam logic [2:0] SEL_ANALOG_UNIPOLAR = 3'h4;
   localparam logic [2:0] SEL_ANALOG_FWD_BOTH = 3'h5;
   localparam logic [2:0] SEL_SWITCH_EXT      = 3'h6;

   // control modes
   localparam logic [1:0] CTRL_POSITION     = 2'h0;
   localparam logic [1:0] CTRL_SPEED        = 2'h1;
   localparam logic [1:0] CTRL_TORQUE       = 2'h2;
   localparam logic [1:0] CTRL_FULLY_CLOSED = 2'h3;

   // timing
   localparam int CLK_PERIOD_NS      = 25;
   localparam int RAMP_TICK_NS       = 1000000;
   localparam int RAMP_TICK_CYCLES   = RAMP_TICK_NS / CLK_PERIOD_NS;
   localparam int FILTER_TICK_NS     = 10000;
   localparam int FILTER_TICK_CYCLES = FILTER_TICK_NS / CLK_PERIOD_NS;

   typedef struct packed {
      logic [LIM_W-1:0] fwd;
      logic [LIM_W-1:0] rev;
   } stls_limits_t;

   typedef enum logic {
      RAMP_IDLE = 1'b0,
      RAMP_RUN  = 1'b1
   } stls_ramp_state_t;
endpackage : stls_pkg

// [verilog/stls_lag_filter.sv]
`timescale 1ns/1ps
module stls_lag_filter (
   input  wire logic                               pclk,
   input  wire logic                               presetn,
   input  wire logic                               tick,
   input  wire logic signed [stls_pkg::AIN_W-1:0]  sample,
   input  wire logic signed [stls_pkg::AIN_W-1:0]  offset,
   input  wire logic        [stls_pkg::TC_W-1:0]   tc,
   output logic signed      [stls_pkg::AIN_W-1:0]  filtered
);
   import stls_pkg::*;
   localparam int ACC_W = AIN_W + FILT_FRAC;

   logic signed [AIN_W:0]   diff;
   logic signed [AIN_W-1:0] adj;
   logic signed [ACC_W-1:0] acc;
   logic signed [ACC_W:0]   err;
   logic signed [ACC_W:0]   step;
   logic signed [ACC_W:0]   sum;

   // offset removal, saturated so a large offset cannot wrap
   always_comb begin
      diff = {sample[AIN_W-1], sample} - {offset[AIN_W-1], offset};
      if (diff[AIN_W] != diff[AIN_W-1]) begin
         adj = diff[AIN_W] ? {1'b1, {(AIN_W-1){1'b0}}} : {1'b0, {(AIN_W-1){1'b1}}};
      end else begin
         adj = diff[AIN_W-1:0];
      end
   end

   // shift-based lag keeps it multiplier free; the time constant is two to the power tc
   always_comb begin
      err  = {adj[AIN_W-1], adj, {FILT_FRAC{1'b0}}} - {acc[ACC_W-1], acc};
      step = err >>> tc;
      sum  = {acc[ACC_W-1], acc} + step;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc <= '0;
      end else if (tick) begin
         acc <= sum[ACC_W-1:0];
      end
   end

   assign filtered = acc[ACC_W-1 -: AIN_W];
endmodule : stls_lag_filter

// [verilog/stls_top.sv]
// Operation
// R1: mode 0: analog fwd positive, rev negative
// R2: mode 1: first stored limit both ways
// R3: mode 2: first forward, second reverse
// R4: mode 3: switch picks first or second
// R5: mode 4: both analog inputs, positive span
// R6: mode 5: forward analog input limits both
// R7: mode 6: stored pair or external pair
// R8: torque control must select first limit; not enforced here, left to the host
// R9: feed-forward limit only speed, modes 1-3
// R10: ramping only in mode 3
// R11: first to second uses first rate
// R12: second to first uses second rate
// R13: ramp direction follows limit magnitudes
// R14: rewriting stored limit skips ramp
// R15: limits 0 to 300, default 300
// R16: pairing cap replaces 300 maximum
// R17: analog voltage times scale gives limit
// R18: analog inputs offset then lag filtered
// R19: network supplies external limits
// R20: switch input mapped to pin, polarity
// R21: every source clamped to pairing cap
//
// Decided for this implementation: the APB register port and the register offsets.
`timescale 1ns/1ps
module stls_top #(
   parameter int RAMP_TICK_CYCLES = stls_pkg::RAMP_TICK_CYCLES
) (
   input  wire logic                                pclk,
   input  wire logic                                presetn,
   input  wire logic        [stls_pkg::ADDR_W-1:0]  paddr,
   input  wire logic                                psel,
   input  wire logic                                penable,
   input  wire logic                                pwrite,
   input  wire logic        [31:0]                  pwdata,
   output logic             [31:0]                  prdata,
   output logic                                     pready,
   output logic                                     pslverr,
   input  wire logic signed [stls_pkg::AIN_W-1:0]   forward_analog_limit_input,
   input  wire logic signed [stls_pkg::AIN_W-1:0]   reverse_analog_limit_input,
   input  wire logic        [stls_pkg::NUM_PINS-1:0] control_pins,
   input  wire logic        [1:0]                   control_mode,
   input  wire logic                                torque_ff_select,
   output stls_pkg::stls_limits_t                   limits,
   output logic                                     limit_enforced
);
   import stls_pkg::*;
   localparam int TICK_W = $clog2(RAMP_TICK_CYCLES);
   localparam int FTICK_W = $clog2(FILTER_TICK_CYCLES);

   logic             [2:0]        limit_source_select;
   logic             [LIM_W-1:0]  first_stored_limit;
   logic             [LIM_W-1:0]  second_stored_limit;
   logic             [LIM_W-1:0]  rate_first_to_second;
   logic             [LIM_W-1:0]  rate_second_to_first;
   logic             [LIM_W-1:0]  forward_external_limit;
   logic             [LIM_W-1:0]  reverse_external_limit;
   logic             [15:0]       analog_limit_scale;
   logic signed      [AIN_W-1:0]  ain2_offset;
   logic             [TC_W-1:0]   ain2_filter_time_constant;
   logic signed      [AIN_W-1:0]  ain3_offset;
   logic             [TC_W-1:0]   ain3_filter_time_constant;
   logic             [LIM_W-1:0]  pairing_max_limit;
   logic             [5:0]        switch_map;
   logic signed      [AIN_W-1:0]  fwd_ain_meta, fwd_ain_s;
   logic signed      [AIN_W-1:0]  rev_ain_meta, rev_ain_s;
   logic             [NUM_PINS-1:0] pins_meta, pins_s;
   logic signed      [AIN_W-1:0]  ain2_filt, ain3_filt;
   logic             [FTICK_W-1:0] ftick_cnt;
   logic                          ftick;
   logic             [TICK_W-1:0] rtick_cnt;
   logic                          rtick;
   logic                          wr_en, rd_setup, addr_ok;
   logic             [31:0]       read_word;
   logic                          snap_pending;
   logic                          limit_switch_input;
   logic             [LIM_W-1:0]  cap, first_c, second_c, target, rate;
   logic             [LIM_W-1:0]  ramp_val;
   stls_ramp_state_t              ramp_state;
   logic             [LIM_W-1:0]  ana_fwd_pos, ana_rev_pos, ana_rev_neg;
   stls_limits_t                  next_limits;
   logic                          next_enforced;

   // analog samples and pins come from outside, two flops each
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fwd_ain_meta <= '0;
         fwd_ain_s    <= '0;
         rev_ain_meta <= '0;
         rev_ain_s    <= '0;
         pins_meta    <= '0;
         pins_s       <= '0;
      end else begin
         fwd_ain_meta <= forward_analog_limit_input;
         fwd_ain_s    <= fwd_ain_meta;
         rev_ain_meta <= reverse_analog_limit_input;
         rev_ain_s    <= rev_ain_meta;
         pins_meta    <= control_pins;
         pins_s       <= pins_meta;
      end
   end

   // apb decode; zero wait states
   assign pready   = psel & penable;
   assign wr_en    = psel & penable & pwrite;
   assign rd_setup = psel & ~penable;

   always_comb begin
      read_word = '0;
      addr_ok   = 1'b1;
      case (paddr)
         OFS_SELECT:   read_word[2:0]        = limit_source_select;
         OFS_FIRST:    read_word[LIM_W-1:0]  = first_stored_limit;
         OFS_SECOND:   read_word[LIM_W-1:0]  = second_stored_limit;
         OFS_RATE12:   read_word[LIM_W-1:0]  = rate_first_to_second;
         OFS_RATE21:   read_word[LIM_W-1:0]  = rate_second_to_first;
         OFS_FWD_EXT:  read_word[LIM_W-1:0]  = forward_external_limit;
         OFS_REV_EXT:  read_word[LIM_W-1:0]  = reverse_external_limit;
         OFS_SCALE:    read_word[15:0]       = analog_limit_scale;
         OFS_AIN2_OFS: read_word[AIN_W-1:0]  = ain2_offset;
         OFS_AIN2_TC:  read_word[TC_W-1:0]   = ain2_filter_time_constant;
         OFS_AIN3_OFS: read_word[AIN_W-1:0]  = ain3_offset;
         OFS_AIN3_TC:  read_word[TC_W-1:0]   = ain3_filter_time_constant;
         OFS_PAIR_MAX: read_word[LIM_W-1:0]  = pairing_max_limit;
         OFS_SW_MAP:   read_word[5:0]        = switch_map;
         OFS_STATUS: begin
            read_word[LIM_W-1:0]                  = limits.fwd;
            read_word[STAT_REV_LSB +: LIM_W]      = limits.rev;
            read_word[STAT_BUSY_BIT]              = ramp_state == RAMP_RUN;
            read_word[STAT_SW_BIT]                = limit_switch_input;
            read_word[STAT_ACT_BIT]               = limit_enforced;
         end
         default: addr_ok = 1'b0;
      endcase
   end

   // read data and error are captured in setup so they stand in access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= '0;
         pslverr <= 1'b0;
      end else if (rd_setup) begin
         prdata  <= pwrite ? 32'h0000_0000 : read_word;
         pslverr <= ~addr_ok | (pwrite & (paddr == OFS_STATUS));
      end
   end

   // configuration writes; stored limits saturate at the range top
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         limit_source_select       <= SEL_DEFAULT;
         first_stored_limit        <= LIM_DEFAULT;      // R15
         second_stored_limit       <= LIM_DEFAULT;
         rate_first_to_second      <= '0;
         rate_second_to_first      <= '0;
         forward_external_limit    <= LIM_DEFAULT;
         reverse_external_limit    <= LIM_DEFAULT;
         analog_limit_scale        <= SCALE_DEFAULT;
         ain2_offset               <= '0;
         ain2_filter_time_constant <= '0;
         ain3_offset               <= '0;
         ain3_filter_time_constant <= '0;
         pairing_max_limit         <= LIM_RANGE_MAX;
         switch_map                <= '0;
      end else if (wr_en) begin
         case (paddr)
            OFS_SELECT:   limit_source_select       <= pwdata[2:0];
            OFS_FIRST:    first_stored_limit        <= sat_lim(pwdata); // R15
            OFS_SECOND:   second_stored_limit       <= sat_lim(pwdata); // R15
            OFS_RATE12:   rate_first_to_second      <= sat_lim(pwdata);
            OFS_RATE21:   rate_second_to_first      <= sat_lim(pwdata);
            OFS_FWD_EXT:  forward_external_limit    <= sat_lim(pwdata); // R19
            OFS_REV_EXT:  reverse_external_limit    <= sat_lim(pwdata); // R19
            OFS_SCALE:    analog_limit_scale        <= pwdata[15:0];
            OFS_AIN2_OFS: ain2_offset               <= pwdata[AIN_W-1:0];
            OFS_AIN2_TC:  ain2_filter_time_constant <= pwdata[TC_W-1:0];
            OFS_AIN3_OFS: ain3_offset               <= pwdata[AIN_W-1:0];
            OFS_AIN3_TC:  ain3_filter_time_constant <= pwdata[TC_W-1:0];
            OFS_PAIR_MAX: pairing_max_limit         <= sat_lim(pwdata); // R16
            OFS_SW_MAP:   switch_map                <= pwdata[5:0];
            default: ;
         endcase
      end
   end

   // a stored-limit rewrite makes the ramp jump one cycle later
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         snap_pending <= 1'b0;
      end else begin
         snap_pending <= wr_en & ((paddr == OFS_FIRST) | (paddr == OFS_SECOND)); // R14
      end
   end

   function automatic logic [LIM_W-1:0] sat_lim(input logic [31:0] v);
      sat_lim = (v > 32'(LIM_RANGE_MAX)) ? LIM_RANGE_MAX : v[LIM_W-1:0];
   endfunction : sat_lim

   function automatic logic [LIM_W-1:0] clamp(input logic [LIM_W-1:0] v,
                                              input logic [LIM_W-1:0] c);
      clamp = (v > c) ? c : v;
   endfunction : clamp

   // voltage magnitude times gain, capped so wide products cannot wrap
   function automatic logic [LIM_W-1:0] to_limit(input logic [AIN_W-1:0] mag,
                                                 input logic [15:0]      gain,
                                                 input logic [LIM_W-1:0] c);
      logic [31:0] prod;
      prod     = 32'(mag) * 32'(gain);
      prod     = prod >> SCALE_SHIFT;
      to_limit = (prod > 32'(c)) ? c : prod[LIM_W-1:0];
   endfunction : to_limit

   // switch input: any pin, optional inversion for break contacts
   always_comb begin
      limit_switch_input = 1'b0;
      if (switch_map[MAP_EN_BIT] && (switch_map[PIN_IDX_W-1:0] < PIN_IDX_W'(NUM_PINS))) begin
         limit_switch_input = pins_s[switch_map[PIN_IDX_W-1:0]] ^ switch_map[MAP_INV_BIT]; // R20
      end
   end

   // filter sample tick
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ftick_cnt <= '0;
         ftick     <= 1'b0;
      end else begin
         ftick     <= ftick_cnt == FTICK_W'(FILTER_TICK_CYCLES - 1);
         ftick_cnt <= (ftick_cnt == FTICK_W'(FILTER_TICK_CYCLES - 1)) ? '0 : ftick_cnt + 1'b1;
      end
   end

   // forward input is analog input 2, reverse is analog input 3
   stls_lag_filter u_ain2 (                                   // R18
      .pclk     (pclk),
      .presetn  (presetn),
      .tick     (ftick),
      .sample   (fwd_ain_s),
      .offset   (ain2_offset),
      .tc       (ain2_filter_time_constant),
      .filtered (ain2_filt)
   );

   stls_lag_filter u_ain3 (                                   // R18
      .pclk     (pclk),
      .presetn  (presetn),
      .tick     (ftick),
      .sample   (rev_ain_s),
      .offset   (ain3_offset),
      .tc       (ain3_filter_time_constant),
      .filtered (ain3_filt)
   );

   // cap and clamped sources; the pairing cap never exceeds 300
   always_comb begin
      cap      = clamp(pairing_max_limit, LIM_RANGE_MAX);                   // R16
      first_c  = clamp(first_stored_limit, cap);                            // R21
      second_c = clamp(second_stored_limit, cap);                           // R21
      target   = limit_switch_input ? second_c : first_c;
      rate     = limit_switch_input ? rate_first_to_second                  // R11
                                    : rate_second_to_first;                 // R12
      ana_fwd_pos = to_limit(ain2_filt[AIN_W-1] ? '0 : ain2_filt,
                             analog_limit_scale, cap);                      // R17
      ana_rev_pos = to_limit(ain3_filt[AIN_W-1] ? '0 : ain3_filt,
                             analog_limit_scale, cap);                      // R17
      ana_rev_neg = to_limit(ain3_filt[AIN_W-1] ? AIN_W'(-ain3_filt) : '0,
                             analog_limit_scale, cap);                      // R17
   end

   // ramp tick
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rtick_cnt <= '0;
         rtick     <= 1'b0;
      end else begin
         rtick     <= rtick_cnt == TICK_W'(RAMP_TICK_CYCLES - 1);
         rtick_cnt <= (rtick_cnt == TICK_W'(RAMP_TICK_CYCLES - 1)) ? '0 : rtick_cnt + 1'b1;
      end
   end

   // ramp follows target; rate zero means one jump to target at the next ramp tick
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ramp_val   <= LIM_DEFAULT;
         ramp_state <= RAMP_IDLE;
      end else if (limit_source_select != SEL_SWITCHED || snap_pending) begin
         ramp_val   <= target;                                             // R10 R14
         ramp_state <= RAMP_IDLE;
      end else begin
         case (ramp_state)
            RAMP_IDLE: begin
               if (ramp_val != target) begin
                  ramp_state <= RAMP_RUN;
               end
            end
            RAMP_RUN: begin
               if (ramp_val == target) begin
                  ramp_state <= RAMP_IDLE;
               end else if (rtick) begin
                  if (rate == '0) begin
                     ramp_val <= target;
                  end else if (ramp_val < target) begin                    // R13
                     ramp_val <= (target - ramp_val <= rate) ? target : ramp_val + rate;
                  end else begin
                     ramp_val <= (ramp_val - target <= rate) ? target : ramp_val - rate;
                  end
               end
            end
            default: ramp_state <= RAMP_IDLE;
         endcase
      end
   end

   // source selection per setting; unknown settings fall back to first
   always_comb begin
      next_limits = '{fwd: first_c, rev: first_c};
      case (limit_source_select)
         SEL_ANALOG_BIPOLAR:  next_limits = '{fwd: ana_fwd_pos, rev: ana_rev_neg}; // R1
         SEL_FIRST_BOTH:      next_limits = '{fwd: first_c, rev: first_c};        // R2
         SEL_FIRST_SECOND:    next_limits = '{fwd: first_c, rev: second_c};       // R3
         SEL_SWITCHED: begin
            next_limits.fwd = clamp(ramp_val, cap);                               // R4 R21
            next_limits.rev = clamp(ramp_val, cap);                               // R4
         end
         SEL_ANALOG_UNIPOLAR: next_limits = '{fwd: ana_fwd_pos, rev: ana_rev_pos}; // R5
         SEL_ANALOG_FWD_BOTH: next_limits = '{fwd: ana_fwd_pos, rev: ana_fwd_pos}; // R6
         SEL_SWITCH_EXT: begin
            if (limit_switch_input) begin                                         // R7
               next_limits.fwd = clamp(forward_external_limit, cap);              // R21
               next_limits.rev = clamp(reverse_external_limit, cap);
            end else begin
               next_limits = '{fwd: first_c, rev: second_c};
            end
         end
         default: next_limits = '{fwd: first_c, rev: first_c};
      endcase
   end

   // torque control relies on the host selecting the first limit
   always_comb begin
      next_enforced = 1'b1;
      if (torque_ff_select) begin
         next_enforced = (control_mode == CTRL_SPEED) &&                          // R9
                         (limit_source_select >= SEL_FIRST_BOTH) &&
                         (limit_source_select <= SEL_SWITCHED);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         limits         <= '{fwd: LIM_DEFAULT, rev: LIM_DEFAULT};
         limit_enforced <= 1'b1;
      end else begin
         limits         <= next_limits;
         limit_enforced <= next_enforced;
      end
   end
endmodule : stls_top

// [tb/stls_sva.sv]
`timescale 1ns/1ps
module stls_sva
   import stls_pkg::*;
(
   input wire logic              pclk,
   input wire logic              presetn,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [31:0]       prdata,
   input wire logic              pready,
   input wire logic              pslverr,
   input wire logic [1:0]        control_mode,
   input wire logic              torque_ff_select,
   input wire stls_limits_t      limits,
   input wire logic              limit_enforced
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // zero wait states; errors flagged after setup
   chk_ready_access: assert property (psel && penable |-> pready)
      else $error("no ready in access");
   chk_err_reads_zero: assert property (psel && penable && !pwrite && pslverr |-> prdata == '0)
      else $error("refused read not zero");
   chk_status_ro: assert property (psel && !penable && pwrite && paddr == OFS_STATUS |=> pslverr)
      else $error("status write accepted");
   chk_unmapped_err: assert property (psel && !penable && paddr > OFS_STATUS |=> pslverr)
      else $error("unmapped accepted");
   chk_limit_range: assert property (limits.fwd <= LIM_RANGE_MAX && limits.rev <= LIM_RANGE_MAX)
      else $error("limit above range");
   chk_reset_default: assert property ($past(!presetn) |-> limits == {LIM_DEFAULT, LIM_DEFAULT})
      else $error("limits not default");
   chk_enforce_plain: assert property (!torque_ff_select |=> limit_enforced)
      else $error("limit dropped");
   chk_enforce_mode: assert property (torque_ff_select && control_mode != CTRL_SPEED |=> !limit_enforced)
      else $error("ff limit outside speed");
   cov_refused: cover property (psel && penable && pslverr);
   cov_ff_off: cover property (torque_ff_select && !limit_enforced);
   cov_low_limit: cover property (limits.fwd < LIM_DEFAULT);
endmodule : stls_sva
bind stls_top stls_sva i_sva (
   .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
   .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .control_mode(control_mode), .torque_ff_select(torque_ff_select),
   .limits(limits), .limit_enforced(limit_enforced));

// [tb/stls_host_model.sv]
`timescale 1ns/1ps
module stls_host_model (
   input  wire logic                               pclk,
   output logic signed [stls_pkg::AIN_W-1:0]       fwd_ain,
   output logic signed [stls_pkg::AIN_W-1:0]       rev_ain,
   output logic        [stls_pkg::NUM_PINS-1:0]    pins
);
   initial {fwd_ain, rev_ain, pins} = '0;
   // switch on pin 2, make contact; levels held
   task automatic drive(input logic [15:0] f, r, input logic sw);
      @(posedge pclk);
      fwd_ain <= f;
      rev_ain <= r;
      pins <= {7'h00, sw, 2'h0};
   endtask : drive
endmodule : stls_host_model

// [tb/stls_top_tb.sv]
`timescale 1ns/1ps
module stls_top_tb;
   import stls_pkg::*;
   logic                    pclk = 1'b0;
   logic                    presetn = 1'b0;
   logic [ADDR_W-1:0]       paddr = '0;
   logic                    psel = 1'b0;
   logic                    penable = 1'b0;
   logic                    pwrite = 1'b0;
   logic [31:0]             pwdata = '0;
   logic [31:0]             prdata;
   logic                    pready;
   logic                    pslverr;
   logic signed [AIN_W-1:0] fa;
   logic signed [AIN_W-1:0] ra;
   logic [NUM_PINS-1:0]     pins;
   logic [1:0]              cmode = CTRL_SPEED;
   logic                    ffsel = 1'b0;
   stls_limits_t            limits;
   logic                    enf;
   logic [31:0]             rdat;
   logic                    rerr;
   int                      n_fail = 0;
   int                      total_checks = 0;
   always #12.5 pclk = ~pclk;
   stls_top #(.RAMP_TICK_CYCLES(4)) i_dut (
      .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .forward_analog_limit_input(fa), .reverse_analog_limit_input(ra), .control_pins(pins),
      .control_mode(cmode), .torque_ff_select(ffsel), .limits(limits), .limit_enforced(enf));
   stls_host_model i_host (.pclk(pclk), .fwd_ain(fa), .rev_ain(ra), .pins(pins));
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : wrap_up
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH %0t got %h want %h", $time, got, exp);
      end
   endtask : chk
   // one apb transfer, held until pready at an edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge pclk);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 9; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (i == 9) begin
         n_fail++;
         wrap_up();
      end
      rdat = prdata; rerr = pslverr; psel <= 1'b0; penable <= 1'b0;
   endtask : apb
   task automatic lim(input int n, input logic [9:0] f, r);
      repeat (n) @(posedge pclk);
      chk(32'(limits), {12'h000, f, r});
   endtask : lim
   task automatic t_regs();
      apb(0, OFS_FIRST, 0); chk(rdat, 32'h12c);
      lim(1, 10'h12c, 10'h12c);
      apb(1, OFS_FIRST, 32'h3ff); apb(0, OFS_FIRST, 0); chk(rdat, 32'h12c);
      apb(0, 8'h3c, 0); chk(32'(rerr), 32'h1);
      apb(1, OFS_STATUS, 32'h1); chk(32'(rerr), 32'h1);
      apb(1, OFS_PAIR_MAX, 32'h0e1); lim(4, 10'h0e1, 10'h0e1);
      apb(1, OFS_PAIR_MAX, 32'h12c);
   endtask : t_regs
   task automatic t_stored();
      apb(1, OFS_FIRST, 32'h064); apb(1, OFS_SECOND, 32'h032);
      lim(4, 10'h064, 10'h064);
      apb(1, OFS_SELECT, 32'h2); lim(4, 10'h064, 10'h032);
      apb(1, OFS_SELECT, 32'h3); lim(4, 10'h064, 10'h064);
      apb(1, OFS_FWD_EXT, 32'h050); apb(1, OFS_REV_EXT, 32'h046);
      apb(1, OFS_SELECT, 32'h6); lim(4, 10'h064, 10'h032);
      apb(1, OFS_SW_MAP, 32'h22); i_host.drive(0, 0, 1); lim(6, 10'h050, 10'h046);
   endtask : t_stored
   // ramp up, rewrite mid-ramp, ramp down
   task automatic t_ramp();
      apb(1, OFS_SELECT, 32'h3); apb(1, OFS_SECOND, 32'h0c8); apb(1, OFS_RATE12, 32'h0a);
      lim(6, 10'h0c8, 10'h0c8);
      i_host.drive(0, 0, 0); lim(9, 10'h064, 10'h064);
      i_host.drive(0, 0, 1); repeat (14) @(posedge pclk);
      chk(32'(limits.fwd > 10'h064 && limits.fwd < 10'h0c8), 32'h1);
      apb(1, OFS_SECOND, 32'h096); lim(4, 10'h096, 10'h096);
      i_host.drive(0, 0, 0); lim(12, 10'h064, 10'h064);
      apb(1, OFS_SECOND, 32'h032); i_host.drive(0, 0, 1); repeat (14) @(posedge pclk);
      chk(32'(limits.fwd > 10'h032 && limits.fwd < 10'h064), 32'h1);
      lim(40, 10'h032, 10'h032);
   endtask : t_ramp
   task automatic t_analog();
      i_host.drive(16'h2710, 16'he0c0, 0); apb(1, OFS_SELECT, 32'h5);
      lim(900, 10'h124, 10'h124);
      i_host.drive(16'h1388, 16'he0c0, 0); apb(1, OFS_SELECT, 32'h0);
      lim(900, 10'h092, 10'h0ea);
      apb(1, OFS_SELECT, 32'h4); lim(4, 10'h092, 10'h000);
      apb(1, OFS_AIN2_OFS, 32'h3e8); lim(900, 10'h075, 10'h000);
   endtask : t_analog
   task automatic t_ff();
      apb(1, OFS_SELECT, 32'h1); @(posedge pclk); ffsel <= 1'b1;
      repeat (3) @(posedge pclk); chk(32'(enf), 32'h1);
      apb(1, OFS_SELECT, 32'h0); repeat (3) @(posedge pclk); chk(32'(enf), 32'h0);
      apb(1, OFS_SELECT, 32'h1); cmode <= CTRL_TORQUE;
      repeat (3) @(posedge pclk); chk(32'(enf), 32'h0);
   endtask : t_ff
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_stored();
      t_ramp();
      t_analog();
      t_ff();
      wrap_up();
   end
endmodule : stls_top_tb
